// file: csr_pkg.sv
// Shared register map, field positions, reset values and operation codes.
package csr_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int BANK_W = 7;
	localparam logic [7:0] IDX_STATUS = 8'h03;
	localparam logic [7:0] IDX_INTCTL = 8'h0B;
	localparam logic [7:0] IDX_PFLAG = 8'h0C;
	localparam logic [7:0] IDX_OPTION = 8'h81;
	localparam logic [7:0] IDX_PEN = 8'h8C;
	localparam logic [7:0] IDX_PWRCTL = 8'h8E;
	localparam logic [1:0] WORD_LSB = 2'h0;
	localparam int ST_IBS = 7;
	localparam int ST_BSH = 6;
	localparam int ST_BSL = 5;
	localparam int ST_TO = 4;
	localparam int ST_PD = 3;
	localparam int ST_Z = 2;
	localparam int ST_DC = 1;
	localparam int ST_C = 0;
	localparam int OP_PUD = 7;
	localparam int OP_EDG = 6;
	localparam int OP_SRC = 5;
	localparam int OP_SE = 4;
	localparam int OP_PSA = 3;
	localparam int OP_PS_LO = 0;
	localparam int PS_W = 3;
	localparam int IC_GIE = 7;
	localparam int IC_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int IC_TIMER_OVERFLOW_IRQ_ENABLE = 5;
	localparam int IC_EDGE_PIN_IRQ_ENABLE = 4;
	localparam int IC_PORT_CHANGE_IRQ_ENABLE = 3;
	localparam int IC_TIMER_OVERFLOW_FLAG = 2;
	localparam int IC_EDGE_PIN_IRQ_FLAG = 1;
	localparam int IC_PORT_CHANGE_FLAG = 0;
	localparam int CM_BIT = 6;
	localparam int PC_POR = 1;
	localparam int PC_BOR = 0;
	localparam int NIB_W = 4;
	localparam int PRE_W = 8;
	localparam int PORTB_HI = 4;
	localparam logic [7:0] RST_STATUS = 8'h18;
	localparam logic [7:0] RST_OPTION = 8'hFF;
	localparam logic [7:0] RST_INTCTL = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] PFLAG_MASK = 8'h40;
	localparam logic [7:0] PWRCTL_MASK = 8'h03;
	typedef enum logic [2:0] {
		CSR_OP_LOGIC,
		CSR_OP_ADD,
		CSR_OP_SUB,
		CSR_OP_ROTL,
		CSR_OP_ROTR
	} csr_op_t;
endpackage

// file: csr_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module csr_sync #(
	parameter int W = 1
) (
	input wire logic clock, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic [W-1:0] d, // Asynchronous pin levels.
	output logic [W-1:0] q // Synchronised levels.
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// file: csr_flag_calc.sv
// Arithmetic flag outcome of one core operation.
`timescale 1ns/1ps
module csr_flag_calc (
	input csr_pkg::csr_op_t op, // Operation kind.
	input wire logic [7:0] a, // First operand or rotate source.
	input wire logic [7:0] b, // Second operand.
	input wire logic [7:0] logic_res, // Result of a logic operation.
	output logic z, // Zero outcome.
	output logic dc, // Nibble carry outcome.
	output logic c, // Carry outcome.
	output logic z_upd, // Zero flag is affected.
	output logic dc_upd, // Nibble carry flag is affected.
	output logic c_upd // Carry flag is affected.
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] bb;
	logic cin;

	// Subtraction adds the inverted operand and a carry in, so a zero operand still carries.
	always_comb begin
		bb = (op == csr_pkg::CSR_OP_SUB) ? ~b : b;
		cin = (op == csr_pkg::CSR_OP_SUB);
		sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
		nib = {1'b0, a[csr_pkg::NIB_W-1:0]} + {1'b0, bb[csr_pkg::NIB_W-1:0]} + {4'h0, cin};
		z = 1'b0;
		dc = 1'b0;
		c = 1'b0;
		z_upd = 1'b0;
		dc_upd = 1'b0;
		c_upd = 1'b0;
		unique case (op)
			csr_pkg::CSR_OP_LOGIC: begin
				z = (logic_res == 8'h00);
				z_upd = 1'b1;
			end
			csr_pkg::CSR_OP_ADD, csr_pkg::CSR_OP_SUB: begin
				z = (sum[7:0] == 8'h00);
				dc = nib[csr_pkg::NIB_W];
				c = sum[8];
				z_upd = 1'b1;
				dc_upd = 1'b1;
				c_upd = 1'b1;
			end
			csr_pkg::CSR_OP_ROTL: begin
				c = a[7];
				c_upd = 1'b1;
			end
			csr_pkg::CSR_OP_ROTR: begin
				c = a[0];
				c_upd = 1'b1;
			end
			default: begin
			end
		endcase
	end
endmodule

// file: csr_regs.sv
// Core status, option and interrupt register set behind an APB slave.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module csr_regs #(
	parameter int PRE_W = csr_pkg::PRE_W
) (
	input wire logic clock, // 100 MHz system clock.
	input wire logic rst_n, // Power-on reset, synchronous, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [csr_pkg::ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [csr_pkg::DATA_W-1:0] pwdata, // APB write data.
	output logic [csr_pkg::DATA_W-1:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped address.
	input wire logic alu_valid, // Core operation completes this cycle.
	input csr_pkg::csr_op_t alu_op, // Kind of that operation.
	input wire logic [7:0] alu_a, // First operand or rotate source.
	input wire logic [7:0] alu_b, // Second operand.
	input wire logic [7:0] alu_logic_res, // Logic operation result.
	input wire logic alu_dest_status, // Operation result is written to status.
	input wire logic [7:0] alu_status_wdata, // Result written to status.
	input wire logic watchdog_clear_instr, // Watchdog clear instruction pulse.
	input wire logic sleep_instr, // Sleep instruction pulse.
	input wire logic watchdog_timeout, // Watchdog timer expiry pulse.
	input wire logic brownout_reset, // Brown-out reset event pulse.
	input wire logic free_timer_overflow, // Free timer overflow pulse.
	input wire logic instruction_cycle_clock, // Instruction cycle tick pulse.
	input wire logic watchdog_base_tick, // Watchdog oscillator tick pulse.
	input wire logic timer_ext_clock_pin, // Timer external clock pin.
	input wire logic edge_irq_pin, // External edge interrupt pin.
	input wire logic [csr_pkg::PORTB_HI-1:0] port_b_high_pins, // Upper port B pins.
	input wire logic comparator_out, // Comparator output level.
	input wire logic [7:0] port_b_latch, // Port B output latch values.
	input wire logic [csr_pkg::BANK_W-1:0] direct_addr, // Direct address from opcode.
	output logic [csr_pkg::BANK_W:0] data_addr, // Banked data memory address.
	output logic [7:0] port_b_pullup_en, // Weak pull-up enables.
	output logic free_timer_inc, // Free timer increment pulse.
	output logic watchdog_inc, // Watchdog increment pulse.
	output logic irq // Interrupt request to the core.
);
	logic [7:0] status_q;
	logic [7:0] option_q;
	logic [7:0] intctl_q;
	logic cmp_flag_q;
	logic cmp_en_q;
	logic [1:0] pwr_q;
	logic [PRE_W-1:0] pre_q;
	logic [2:0] tck_s;
	logic tck_prev_q;
	logic int_prev_q;
	logic [csr_pkg::PORTB_HI-1:0] pb_s;
	logic [csr_pkg::PORTB_HI-1:0] pb_prev_q;
	logic cmp_prev_q;
	logic [2:0] pin_arm_q;
	logic z_n, dc_n, c_n, z_u, dc_u, c_u;
	logic [csr_pkg::ADDR_W-3:0] idx;
	logic hit;
	logic wr_en;
	logic [7:0] wd;
	logic [7:0] rd_d;
	logic tck_rise, tck_fall, ext_evt, src_evt, pre_src, pre_done;
	logic int_evt, pb_evt, cmp_evt;
	localparam int PS_SH_W = 4;
	logic [PRE_W-1:0] pre_lim;
	logic [PS_SH_W-1:0] shamt;

	csr_sync #(
		.W(csr_pkg::PORTB_HI + 3)
	) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.d({port_b_high_pins, comparator_out, edge_irq_pin, timer_ext_clock_pin}),
		.q({pb_s, tck_s})
	);

	csr_flag_calc u_flags (
		.op(alu_op),
		.a(alu_a),
		.b(alu_b),
		.logic_res(alu_logic_res),
		.z(z_n),
		.dc(dc_n),
		.c(c_n),
		.z_upd(z_u),
		.dc_upd(dc_u),
		.c_upd(c_u)
	);

	// Register index is the byte address divided by four.
	assign idx = paddr[csr_pkg::ADDR_W-1:2];
	assign wd = pwdata[7:0];
	assign wr_en = psel && penable && pready && pwrite && hit;

	always_comb begin
		hit = (paddr[1:0] == csr_pkg::WORD_LSB);
		rd_d = 8'h00;
		unique case (idx)
			csr_pkg::IDX_STATUS: rd_d = status_q;
			csr_pkg::IDX_INTCTL: rd_d = intctl_q;
			csr_pkg::IDX_PFLAG: rd_d = {1'b0, cmp_flag_q, 6'h00};
			csr_pkg::IDX_OPTION: rd_d = option_q;
			csr_pkg::IDX_PEN: rd_d = {1'b0, cmp_en_q, 6'h00};
			csr_pkg::IDX_PWRCTL: rd_d = {6'h00, pwr_q};
			default: hit = 1'b0;
		endcase
	end

	// One wait state: ready rises in the second access cycle.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !hit;
			prdata <= (psel && penable && !pready && !pwrite && hit) ?
				{{(csr_pkg::DATA_W-8){1'b0}}, rd_d} : '0;
		end
	end

	// Edge, port change and comparator pin events count only once the synchroniser and history hold real pin levels; timer pin edges are not held off.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tck_prev_q <= 1'b0;
			int_prev_q <= 1'b0;
			pb_prev_q <= '0;
			cmp_prev_q <= 1'b0;
			pin_arm_q <= '0;
		end else begin
			tck_prev_q <= tck_s[0];
			int_prev_q <= tck_s[1];
			cmp_prev_q <= tck_s[2];
			pb_prev_q <= pb_s;
			pin_arm_q <= {pin_arm_q[1:0], 1'b1};
		end
	end

	always_comb begin
		tck_rise = tck_s[0] && !tck_prev_q;
		tck_fall = !tck_s[0] && tck_prev_q;
		ext_evt = option_q[csr_pkg::OP_SE] ? tck_fall : tck_rise;
		src_evt = option_q[csr_pkg::OP_SRC] ? ext_evt : instruction_cycle_clock;
		int_evt = pin_arm_q[2] && (option_q[csr_pkg::OP_EDG] ?
			(tck_s[1] && !int_prev_q) : (!tck_s[1] && int_prev_q));
		pb_evt = pin_arm_q[2] && (pb_s != pb_prev_q);
		cmp_evt = pin_arm_q[2] && (tck_s[2] != cmp_prev_q);
		pre_src = option_q[csr_pkg::OP_PSA] ? watchdog_base_tick : src_evt;
		shamt = option_q[csr_pkg::OP_PSA] ?
			{1'b0, option_q[csr_pkg::OP_PS_LO +: csr_pkg::PS_W]} :
			{1'b0, option_q[csr_pkg::OP_PS_LO +: csr_pkg::PS_W]} + 4'h1;
		pre_lim = PRE_W'((9'h001 << shamt) - 9'h001);
		pre_done = pre_src && (pre_q == pre_lim);
	end

	// Shared prescaler counts events of whichever unit owns it.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pre_q <= '0;
		end else if (wr_en && idx == csr_pkg::IDX_OPTION) begin
			pre_q <= '0;
		end else if (pre_done) begin
			pre_q <= '0;
		end else if (pre_src) begin
			pre_q <= pre_q + PRE_W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			free_timer_inc <= 1'b0;
			watchdog_inc <= 1'b0;
		end else if (option_q[csr_pkg::OP_PSA]) begin
			free_timer_inc <= src_evt;
			watchdog_inc <= pre_done;
		end else begin
			free_timer_inc <= pre_done;
			watchdog_inc <= watchdog_base_tick;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			option_q <= csr_pkg::RST_OPTION;
		end else if (wr_en && idx == csr_pkg::IDX_OPTION) begin
			option_q <= wd;
		end
	end

	// Status register: flag updates win over writes; a write wins over an operation result written to status.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			status_q <= csr_pkg::RST_STATUS;
		end else begin
			if (wr_en && idx == csr_pkg::IDX_STATUS) begin
				status_q[csr_pkg::ST_IBS] <= wd[csr_pkg::ST_IBS];
				status_q[csr_pkg::ST_BSH] <= wd[csr_pkg::ST_BSH];
				status_q[csr_pkg::ST_BSL] <= wd[csr_pkg::ST_BSL];
				status_q[csr_pkg::ST_Z] <= wd[csr_pkg::ST_Z];
				status_q[csr_pkg::ST_DC] <= wd[csr_pkg::ST_DC];
				status_q[csr_pkg::ST_C] <= wd[csr_pkg::ST_C];
			end else if (alu_valid && alu_dest_status) begin
				status_q[csr_pkg::ST_IBS] <= alu_status_wdata[csr_pkg::ST_IBS];
				status_q[csr_pkg::ST_BSH] <= alu_status_wdata[csr_pkg::ST_BSH];
				status_q[csr_pkg::ST_BSL] <= alu_status_wdata[csr_pkg::ST_BSL];
				if (!z_u)
					status_q[csr_pkg::ST_Z] <= alu_status_wdata[csr_pkg::ST_Z];
				if (!dc_u)
					status_q[csr_pkg::ST_DC] <= alu_status_wdata[csr_pkg::ST_DC];
				if (!c_u)
					status_q[csr_pkg::ST_C] <= alu_status_wdata[csr_pkg::ST_C];
			end
			if (alu_valid && z_u)
				status_q[csr_pkg::ST_Z] <= z_n;
			if (alu_valid && dc_u)
				status_q[csr_pkg::ST_DC] <= dc_n;
			if (alu_valid && c_u)
				status_q[csr_pkg::ST_C] <= c_n;
			if (watchdog_timeout)
				status_q[csr_pkg::ST_TO] <= 1'b0;
			else if (watchdog_clear_instr || sleep_instr)
				status_q[csr_pkg::ST_TO] <= 1'b1;
			if (sleep_instr)
				status_q[csr_pkg::ST_PD] <= 1'b0;
			else if (watchdog_clear_instr)
				status_q[csr_pkg::ST_PD] <= 1'b1;
		end
	end

	// Interrupt control: event sets win over a software clear.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			intctl_q <= csr_pkg::RST_INTCTL;
		end else begin
			if (wr_en && idx == csr_pkg::IDX_INTCTL)
				intctl_q <= wd;
			if (free_timer_overflow)
				intctl_q[csr_pkg::IC_TIMER_OVERFLOW_FLAG] <= 1'b1;
			if (int_evt)
				intctl_q[csr_pkg::IC_EDGE_PIN_IRQ_FLAG] <= 1'b1;
			if (pb_evt)
				intctl_q[csr_pkg::IC_PORT_CHANGE_FLAG] <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cmp_flag_q <= 1'b0;
			cmp_en_q <= 1'b0;
		end else begin
			if (wr_en && idx == csr_pkg::IDX_PEN)
				cmp_en_q <= wd[csr_pkg::CM_BIT];
			if (cmp_evt)
				cmp_flag_q <= 1'b1;
			else if (wr_en && idx == csr_pkg::IDX_PFLAG)
				cmp_flag_q <= wd[csr_pkg::CM_BIT];
		end
	end

	// Power control flags; power-on reset clears both.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pwr_q <= 2'h0;
		end else begin
			if (wr_en && idx == csr_pkg::IDX_PWRCTL)
				pwr_q <= wd[1:0] & csr_pkg::PWRCTL_MASK[1:0];
			if (brownout_reset)
				pwr_q[csr_pkg::PC_BOR] <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq <= 1'b0;
			data_addr <= '0;
			port_b_pullup_en <= 8'h00;
		end else begin
			irq <= intctl_q[csr_pkg::IC_GIE] && (
				(intctl_q[csr_pkg::IC_TIMER_OVERFLOW_FLAG] && intctl_q[csr_pkg::IC_TIMER_OVERFLOW_IRQ_ENABLE]) ||
				(intctl_q[csr_pkg::IC_EDGE_PIN_IRQ_FLAG] && intctl_q[csr_pkg::IC_EDGE_PIN_IRQ_ENABLE]) ||
				(intctl_q[csr_pkg::IC_PORT_CHANGE_FLAG] && intctl_q[csr_pkg::IC_PORT_CHANGE_IRQ_ENABLE]) ||
				(intctl_q[csr_pkg::IC_PERIPHERAL_IRQ_ENABLE] && cmp_flag_q && cmp_en_q));
			data_addr <= {status_q[csr_pkg::ST_BSL], direct_addr};
			port_b_pullup_en <= option_q[csr_pkg::OP_PUD] ? 8'h00 : port_b_latch;
		end
	end
endmodule

// file: csr_regs_props.sv
// Concurrent checks on the core register set ports.
`timescale 1ns/1ps
module csr_regs_props (
	input wire logic clock, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic psel, // Select.
	input wire logic penable, // Access phase.
	input wire logic pwrite, // Direction.
	input wire logic [csr_pkg::ADDR_W-1:0] paddr, // Address.
	input wire logic [csr_pkg::DATA_W-1:0] pwdata, // Write data.
	input wire logic [csr_pkg::DATA_W-1:0] prdata, // Read data.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	input wire logic [csr_pkg::BANK_W-1:0] direct_addr, // Direct address.
	input wire logic [csr_pkg::BANK_W:0] data_addr, // Banked address.
	input wire logic [7:0] port_b_latch, // Port latch.
	input wire logic [7:0] port_b_pullup_en, // Pull-up enables.
	input wire logic irq // Interrupt request.
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic gie_off_wr;
	assign gie_off_wr = psel && penable && pready && pwrite && paddr == 12'h02C && !pwdata[7];
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	property p_unused;
		pready && !pwrite && (paddr == 12'h030 || paddr == 12'h230)
			|-> (prdata & 32'hFFFFFFBF) == 32'h00000000;
	endproperty
	property p_pull;
		$past(rst_n, 2) && port_b_pullup_en != 8'h00 |-> port_b_pullup_en == $past(port_b_latch);
	endproperty
	chk_wait_state: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
		else $error("ready not after one wait state");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	chk_err_misalign: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access without error");
	chk_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
		else $error("refused read returned data");
	chk_periph_unused: assert property (p_unused)
		else $error("unimplemented peripheral bits read nonzero");
	chk_bank_addr: assert property ($past(rst_n, 2) |-> data_addr[6:0] == $past(direct_addr))
		else $error("banked address low part wrong");
	chk_pullup_follow: assert property (p_pull)
		else $error("pull-up enables differ from latch");
	chk_gie_blocks: assert property (gie_off_wr |=> ##1 !irq)
		else $error("request with global enable clear");
endmodule
bind csr_regs csr_regs_props csr_regs_props_i (.clock(clock), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .direct_addr(direct_addr), .data_addr(data_addr),
	.port_b_latch(port_b_latch), .port_b_pullup_en(port_b_pullup_en), .irq(irq));

// file: tb_csr_regs.sv
// Self-checking testbench for the core register set.
`timescale 1ns/1ps
module tb_csr_regs;
	logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, alu_valid = 0, alu_dest = 0;
	logic tpin = 0, epin = 0, cmp = 0, err, irq, tinc_o, winc_o;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr;
	logic [6:0] evt = 0, da = 0;
	csr_pkg::csr_op_t alu_op = csr_pkg::CSR_OP_LOGIC;
	logic [7:0] alu_a = 0, alu_b = 0, alu_lr = 0, alu_wd = 0, latch = 0, rd, st, w, pu, data_addr;
	logic [3:0] pbh = 0;
	logic [11:0] ra[6] = '{12'h00C, 12'h02C, 12'h030, 12'h204, 12'h230, 12'h238};
	logic [7:0] rv[6] = '{csr_pkg::RST_STATUS, 8'h00, 8'h00, csr_pkg::RST_OPTION, 8'h00, 8'h00};
	int miscompares = 0, n_tests = 0, seed = 32'h39A41D67, cyc = 0, tinc = 0, winc = 0;
	always #5 clock = ~clock;
	csr_regs csr_regs_i (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
		.alu_logic_res(alu_lr), .alu_dest_status(alu_dest), .alu_status_wdata(alu_wd),
		.watchdog_clear_instr(evt[0]), .sleep_instr(evt[1]), .watchdog_timeout(evt[2]),
		.brownout_reset(evt[3]), .free_timer_overflow(evt[4]), .instruction_cycle_clock(evt[5]),
		.watchdog_base_tick(evt[6]), .timer_ext_clock_pin(tpin), .edge_irq_pin(epin),
		.port_b_high_pins(pbh), .comparator_out(cmp), .port_b_latch(latch), .direct_addr(da),
		.data_addr(data_addr), .port_b_pullup_en(pu), .free_timer_inc(tinc_o),
		.watchdog_inc(winc_o), .irq(irq));
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		tinc += (tinc_o === 1'b1);
		winc += (winc_o === 1'b1);
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string n);
		apb(0, a, 8'h00);
		chk(n, rd, e);
	endtask
	task automatic pulse(input logic [6:0] m);
		@(posedge clock);
		evt <= m;
		@(posedge clock);
		evt <= 7'h00;
	endtask
	task automatic alu(input csr_pkg::csr_op_t o, input logic [7:0] a, b, l, input logic d);
		@(posedge clock);
		alu_valid <= 1;
		alu_op <= o;
		alu_a <= a;
		alu_b <= b;
		alu_lr <= l;
		alu_dest <= d;
		alu_wd <= 8'h07;
		@(posedge clock);
		alu_valid <= 0;
		alu_dest <= 0;
	endtask
	function automatic logic [2:0] flg(csr_pkg::csr_op_t o, logic [7:0] a, b, l, logic [2:0] f);
		logic [7:0] nb;
		int s;
		nb = (o == csr_pkg::CSR_OP_SUB) ? ~b : b;
		s = a + nb + (o == csr_pkg::CSR_OP_SUB);
		case (o)
			csr_pkg::CSR_OP_LOGIC: return {l == 8'h00, f[1:0]};
			csr_pkg::CSR_OP_ROTL: return {f[2:1], a[7]};
			csr_pkg::CSR_OP_ROTR: return {f[2:1], a[0]};
			default: return {s % 256 == 0, a[3:0] + nb[3:0] + (o == csr_pkg::CSR_OP_SUB) > 15, s > 255};
		endcase
	endfunction
	// Pulses both tick inputs 16 times and toggles the timer pin tg times.
	task automatic cnt(input logic [7:0] o, input int tg, input int et, input int ew);
		int t0, w0;
		apb(1, 12'h204, o);
		t0 = tinc;
		w0 = winc;
		for (int i = 0; i < 16; i++) begin
			@(posedge clock);
			evt <= 7'h60;
			if (i < tg) tpin <= ~tpin;
			@(posedge clock);
			evt <= 7'h00;
			repeat (2) @(posedge clock);
		end
		repeat (6) @(posedge clock);
		chk("timer increments", tinc - t0, et);
		chk("watchdog increments", winc - w0, ew);
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1;
		for (int i = 0; i < 6; i++) rdc(ra[i], rv[i], "reset value");
		st = csr_pkg::RST_STATUS;
		apb(0, 12'h010, 8'h00);
		chk("unmapped read", {err, rd}, 9'h100);
		apb(1, 12'h00D, 8'h20);
		chk("misaligned error", err, 1'b1);
		apb(0, 12'h00E, 8'h00);
		chk("misaligned read", {err, rd}, 9'h100);
		w = 8'($random(seed)) & 8'h3F;
		apb(1, 12'h00C, w);
		st = (w & 8'hE7) | (st & 8'h18);
		rdc(12'h00C, st, "status write");
		da <= 7'($random(seed));
		repeat (3) @(posedge clock);
		chk("banked address", data_addr, {st[5], da});
		$display("test registers done");
		for (int i = 0; i < 15; i++) begin
			w = 8'($random(seed));
			alu(csr_pkg::csr_op_t'(i % 5), w, i < 5 ? w : 8'($random(seed)),
				i < 5 ? 8'h00 : 8'($random(seed)), 0);
			st[2:0] = flg(csr_pkg::csr_op_t'(i % 5), alu_a, alu_b, alu_lr, st[2:0]);
			rdc(12'h00C, st, "operation flags");
		end
		alu(csr_pkg::CSR_OP_ADD, 8'h00, 8'h00, 8'h00, 1);
		st = {3'b000, st[4:3], 3'b100};
		rdc(12'h00C, st, "status as destination");
		pulse(7'h02);
		st[4:3] = 2'b10;
		rdc(12'h00C, st, "after sleep");
		pulse(7'h04);
		st[4] = 0;
		rdc(12'h00C, st, "after timeout");
		pulse(7'h01);
		st[4:3] = 2'b11;
		rdc(12'h00C, st, "after watchdog clear");
		$display("test status done");
		for (int prescaler_owner = 0; prescaler_owner < 2; prescaler_owner++)
			for (int p = 0; p < 3; p++)
				cnt(8'(prescaler_owner * 8 + p), 0, prescaler_owner ? 16 : 16 >> (p + 1), prescaler_owner ? 16 >> p : 16);
		cnt(8'h38, 7, 3, 16);
		cnt(8'h28, 5, 2, 16);
		$display("test prescaler done");
		latch <= 8'($random(seed)) | 8'h01;
		apb(1, 12'h204, 8'h40);
		repeat (2) @(posedge clock);
		chk("pull-ups enabled", pu, latch);
		epin <= 1;
		pbh <= pbh ^ (4'($random(seed)) | 4'h1);
		cmp <= 1;
		pulse(7'h10);
		repeat (6) @(posedge clock);
		rdc(12'h02C, 8'h07, "core flags");
		rdc(12'h030, 8'h40, "comparator flag");
		chk("irq masked", irq, 1'b0);
		apb(1, 12'h02C, 8'h97);
		repeat (2) @(posedge clock);
		chk("irq enabled", irq, 1'b1);
		apb(1, 12'h02C, 8'h80);
		epin <= 0;
		repeat (6) @(posedge clock);
		chk("irq cleared", irq, 1'b0);
		rdc(12'h02C, 8'h80, "falling edge ignored");
		apb(1, 12'h204, 8'h00);
		epin <= 1;
		repeat (6) @(posedge clock);
		rdc(12'h02C, 8'h80, "rising edge ignored");
		epin <= 0;
		repeat (6) @(posedge clock);
		rdc(12'h02C, 8'h82, "falling edge flag");
		apb(1, 12'h230, 8'hFF);
		rdc(12'h230, 8'h40, "peripheral enable");
		chk("peripheral masked", irq, 1'b0);
		apb(1, 12'h02C, 8'hC0);
		repeat (2) @(posedge clock);
		chk("peripheral irq", irq, 1'b1);
		apb(1, 12'h02C, 8'h00);
		apb(1, 12'h204, 8'hC0);
		repeat (2) @(posedge clock);
		chk("pull-ups disabled", pu, 8'h00);
		$display("test interrupts done");
		apb(1, 12'h238, 8'h03);
		rdc(12'h238, 8'h03, "power flags set");
		pulse(7'h08);
		rdc(12'h238, 8'h02, "brownout seen");
		$display("test power done");
		final_report();
	end
endmodule
